// ### pkg/tm_pkg.sv
package tm_pkg;

    // --------------------------------------------------------------------
    // widths
    // --------------------------------------------------------------------
    localparam int CNT_W  = 10;   // counter and compare a width
    localparam int BYTE_W = 8;    // low byte and holding buffer width
    localparam int CKS_W  = 3;    // clock select field width
    localparam int RP_W   = 3;    // period compare field width

    // --------------------------------------------------------------------
    // register byte addresses (one aligned word each)
    // --------------------------------------------------------------------
    localparam logic [11:0] CTRL0_OFF  = 12'h000;  // pause, clock select, on, period
    localparam logic [11:0] CTRL1_OFF  = 12'h004;  // mode, output fn, polarity, clear sel
    localparam logic [11:0] CNTL_OFF   = 12'h008;  // counter low byte
    localparam logic [11:0] CNTH_OFF   = 12'h00C;  // counter high byte
    localparam logic [11:0] CMPL_OFF   = 12'h010;  // compare a low byte
    localparam logic [11:0] CMPH_OFF   = 12'h014;  // compare a high byte
    localparam logic [11:0] PINSEL_OFF = 12'h018;  // output pin select and inversion
    localparam logic [11:0] IRQST_OFF  = 12'h01C;  // sticky interrupt status
    localparam logic [11:0] IRQMSK_OFF = 12'h020;  // interrupt mask

    // --------------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------------
    localparam int C0_PAUSE = 7;  // ctrl0 pause bit
    localparam int C0_CKS   = 4;  // ctrl0 clock select lsb
    localparam int C0_ON    = 3;  // ctrl0 on bit
    localparam int C0_RP    = 0;  // ctrl0 period lsb
    localparam int C1_MODE  = 6;  // ctrl1 mode lsb
    localparam int C1_IO    = 4;  // ctrl1 output function lsb
    localparam int C1_OC    = 3;  // ctrl1 initial output level
    localparam int C1_POL   = 2;  // ctrl1 output polarity
    localparam int C1_CCLR  = 0;  // ctrl1 clear select: 0 period, 1 compare a
    localparam int IRQ_W    = 3;  // a match, period match, overflow

    // --------------------------------------------------------------------
    // clock select codes
    // --------------------------------------------------------------------
    localparam logic [2:0] CKS_SYS4  = 3'h0;  // system clock / 4
    localparam logic [2:0] CKS_SYS   = 3'h1;  // system clock
    localparam logic [2:0] CKS_H16   = 3'h2;  // high clock / 16
    localparam logic [2:0] CKS_H64   = 3'h3;  // high clock / 64
    localparam logic [2:0] CKS_SUBA  = 3'h4;  // subsidiary clock
    localparam logic [2:0] CKS_SUBB  = 3'h5;  // subsidiary clock
    localparam logic [2:0] CKS_RISE  = 3'h6;  // external input rising
    localparam logic [2:0] CKS_FALL  = 3'h7;  // external input falling

    // --------------------------------------------------------------------
    // operating modes and output functions
    // --------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_CMP   = 2'h0,  // compare match output
        MODE_CAP   = 2'h1,  // capture input (standard type only)
        MODE_PWM   = 2'h2,  // edge pwm
        MODE_TIMER = 2'h3   // timer / counter
    } mode_t;

    localparam logic [1:0] IO_NONE = 2'h0;  // no change / pwm inactive
    localparam logic [1:0] IO_LOW  = 2'h1;  // drive low / pwm active
    localparam logic [1:0] IO_HIGH = 2'h2;  // drive high / pwm output
    localparam logic [1:0] IO_TOG  = 2'h3;  // toggle

    // prescale dividers
    localparam int DIV4  = 4;
    localparam int DIV16 = 16;
    localparam int DIV64 = 64;

endpackage

// ### rtl/tm_clock_sel.sv
`timescale 1ns/1ps
// picks the counter tick from internal ratios or the external pin
module tm_clock_sel (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // selection
    input  wire logic [2:0]  clock_select_field,
    // sources, already synchronised
    input  wire logic        high_clock_tick,
    input  wire logic        sub_clock_tick,
    input  wire logic        ext_sync,
    // result
    output logic             tick,
    output logic             ext_routed
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [5:0] sys_div;  // system clock prescaler
        logic [5:0] h_div;    // high clock prescaler
        logic       ext_q;    // last external level
    } clk_state_t;

    clk_state_t st;       // registered state
    clk_state_t next_st;  // next state

    // ------------------------------------------------------------------
    // prescalers and edge detect
    // ------------------------------------------------------------------
    always_comb begin
        next_st         = st;
        next_st.sys_div = st.sys_div + 6'h01;
        next_st.ext_q   = ext_sync;
        if (high_clock_tick) begin
            next_st.h_div = st.h_div + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // source mux
    // ------------------------------------------------------------------
    // clock source mux
    always_comb begin
        case (clock_select_field)
            tm_pkg::CKS_SYS4: tick = (st.sys_div[1:0] == 2'h3);
            tm_pkg::CKS_SYS:  tick = 1'b1;
            tm_pkg::CKS_H16:  tick = high_clock_tick && (st.h_div[3:0] == 4'hF);
            tm_pkg::CKS_H64:  tick = high_clock_tick && (st.h_div == 6'h3F);
            tm_pkg::CKS_SUBA: tick = sub_clock_tick;
            tm_pkg::CKS_SUBB: tick = sub_clock_tick;
            tm_pkg::CKS_RISE: tick = ext_sync && !st.ext_q;
            tm_pkg::CKS_FALL: tick = !ext_sync && st.ext_q;
            default:          tick = 1'b0;
        endcase
    end

    assign ext_routed = clock_select_field[2] && clock_select_field[1];

endmodule // tm_clock_sel

// ### rtl/tm_byte_access.sv
`timescale 1ns/1ps
// low/high byte access with the shared 8-bit holding buffer
module tm_byte_access (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // strobes from the bus slave
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic        rd_high,
    input  wire logic [7:0]  wdata,
    // live 10-bit value that a high read latches from
    input  wire logic [9:0]  live_value,
    // results
    output logic      [7:0]  buffer,
    output logic      [9:0]  stored,
    output logic             stored_load
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] buf_q;  // holding buffer
        logic [9:0] value;  // stored compare value
    } byte_state_t;

    byte_state_t st;       // registered state
    byte_state_t next_st;  // next state

    // ------------------------------------------------------------------
    // buffer transfers
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (wr_low) begin
            next_st.buf_q = wdata;
        end
        // high write copies buffer to low
        if (wr_high) begin
            next_st.value = {wdata[1:0], st.buf_q};
        end
        if (rd_high) begin
            next_st.buf_q = live_value[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign buffer      = st.buf_q;
    assign stored      = st.value;
    assign stored_load = wr_high;

endmodule // tm_byte_access

// ### rtl/tm_core.sv
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - two modules on a 10-bit counter
// - timer, capture, compare, pwm modes
// - three-bit field selects counter clock
// - external input edge rising or falling
// - pin routed only when selected
// - match raises interrupt, clears, drives pin
// - separate a and period interrupts
// - compare drives high, low or toggles
// - output pin carries pwm waveform
// - compact type has complementary output pair
// - select bit enables each output pin
// - counter and compare a split bytes
// - low bytes go through holding buffer
// - high write commits buffered low byte
// - high read latches low into buffer
module tm_core #(
    // ten-bit counter, standard or compact type
    parameter bit STANDARD = 1'b0  // 1 standard type, 0 compact type
) (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // clock sources
    input  wire logic        high_clock_tick,
    input  wire logic        sub_clock_tick,
    input  wire logic        external_count_input,
    // pins
    input  wire logic        capture_input,
    output logic             timer_output_pin_a,
    output logic             timer_output_pin_b,
    output logic             timer_output_en_a,
    output logic             timer_output_en_b,
    output logic             ext_input_routed,
    // interrupt
    output logic             irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  ctrl0;      // pause, clock select, on, period
        logic [7:0]  ctrl1;      // mode, output fn, init, pol, clear sel
        logic [3:0]  pinsel;     // [0] out a sel, [1] out b sel, [2] inv a, [3] inv b
        logic [9:0]  count;      // counter
        logic        out_q;      // output level
        logic [2:0]  status;     // sticky events
        logic [2:0]  mask;       // interrupt mask
        logic [1:0]  ext_sync;   // pin synchroniser
        logic [1:0]  cap_sync;   // capture synchroniser
        logic        cap_q;      // last capture level
        logic [31:0] rdata;      // read data
    } core_state_t;

    core_state_t st;       // registered state
    core_state_t next_st;  // next state

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic        acc;        // access phase
    logic        wr;         // write strobe
    logic        rd;         // read in setup phase
    logic [9:0]  cmp_a;      // compare a value
    logic [7:0]  cmp_buf;    // compare holding buffer
    logic [7:0]  cnt_buf;    // counter holding buffer
    logic        tick;       // counter tick
    logic        ext_routed; // pin routed to clock

    assign acc     = psel && penable;
    assign wr      = acc && pwrite;
    assign rd      = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign prdata  = st.rdata;

    // decodes an address against a register
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    assign pslverr = acc && !(hit(paddr, tm_pkg::CTRL0_OFF) || hit(paddr, tm_pkg::CTRL1_OFF)
                     || hit(paddr, tm_pkg::CNTL_OFF) || hit(paddr, tm_pkg::CNTH_OFF)
                     || hit(paddr, tm_pkg::CMPL_OFF) || hit(paddr, tm_pkg::CMPH_OFF)
                     || hit(paddr, tm_pkg::PINSEL_OFF) || hit(paddr, tm_pkg::IRQST_OFF)
                     || hit(paddr, tm_pkg::IRQMSK_OFF));

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    tm_clock_sel u_clk (
        .pclk               (pclk),
        .presetn            (presetn),
        .clock_select_field (st.ctrl0[tm_pkg::C0_CKS +: tm_pkg::CKS_W]),
        .high_clock_tick    (high_clock_tick),
        .sub_clock_tick     (sub_clock_tick),
        .ext_sync           (st.ext_sync[1]),
        .tick               (tick),
        .ext_routed         (ext_routed)
    );

    // a high read latches its low byte at the setup edge, the same edge that
    // captures the high data, so a running counter still reads as one value
    // compare a byte pair
    tm_byte_access u_cmp (
        .pclk        (pclk),
        .presetn     (presetn),
        .wr_low      (wr && hit(paddr, tm_pkg::CMPL_OFF)),
        .wr_high     (wr && hit(paddr, tm_pkg::CMPH_OFF)),
        .rd_high     (rd && hit(paddr, tm_pkg::CMPH_OFF)),
        .wdata       (pwdata[7:0]),
        .live_value  (cmp_a),
        .buffer      (cmp_buf),
        .stored      (cmp_a),
        .stored_load ()
    );

    tm_byte_access u_cnt (
        .pclk        (pclk),
        .presetn     (presetn),
        .wr_low      (1'b0),
        .wr_high     (1'b0),
        .rd_high     (rd && hit(paddr, tm_pkg::CNTH_OFF)),
        .wdata       (8'h00),
        .live_value  (st.count),
        .buffer      (cnt_buf),
        .stored      (),
        .stored_load ()
    );

    // ------------------------------------------------------------------
    // counter decode
    // ------------------------------------------------------------------
    logic        on;         // counter enabled
    logic        paused;     // counter paused
    logic        run;        // counter steps this cycle
    logic [1:0]  mode;       // operating mode
    logic [1:0]  iofn;       // output function
    logic        match_a;    // compare a match
    logic        match_p;    // period match
    logic        ovf;        // wrap at all ones
    logic        on_rise;    // on bit rising
    logic [2:0]  rp;         // period field
    logic        cap_edge;   // capture edge

    assign on      = st.ctrl0[tm_pkg::C0_ON];
    assign paused  = st.ctrl0[tm_pkg::C0_PAUSE];
    assign run     = on && !paused && tick;
    assign mode    = st.ctrl1[tm_pkg::C1_MODE +: 2];
    assign iofn    = st.ctrl1[tm_pkg::C1_IO +: 2];
    assign rp      = st.ctrl0[tm_pkg::C0_RP +: tm_pkg::RP_W];
    assign match_a = run && (st.count == cmp_a);
    assign match_p = run && (rp != 3'h0) && (st.count[9:7] == rp);
    assign ovf     = run && (st.count == 10'h3FF);
    assign on_rise = wr && hit(paddr, tm_pkg::CTRL0_OFF) && pwdata[tm_pkg::C0_ON] && !on;
    assign cap_edge = STANDARD && (mode == tm_pkg::MODE_CAP)
                      && (st.cap_sync[1] != st.cap_q);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st          = st;
        next_st.ext_sync = {st.ext_sync[0], external_count_input};
        next_st.cap_sync = {st.cap_sync[0], capture_input};
        next_st.cap_q    = st.cap_sync[1];

        if (run) begin
            next_st.count = st.count + 10'h001;
        end
        if ((st.ctrl1[tm_pkg::C1_CCLR] && match_a) || (!st.ctrl1[tm_pkg::C1_CCLR] && match_p)) begin
            next_st.count = '0;
        end

        if (mode == tm_pkg::MODE_CMP && match_a) begin
            case (iofn)
                tm_pkg::IO_LOW:  next_st.out_q = 1'b0;
                tm_pkg::IO_HIGH: next_st.out_q = 1'b1;
                tm_pkg::IO_TOG:  next_st.out_q = !st.out_q;
                default:         next_st.out_q = st.out_q;
            endcase
        end else if (mode == tm_pkg::MODE_PWM) begin
            case (iofn)
                tm_pkg::IO_NONE: next_st.out_q = 1'b0;
                tm_pkg::IO_LOW:  next_st.out_q = 1'b1;
                tm_pkg::IO_HIGH: next_st.out_q = (st.count < cmp_a);
                default:         next_st.out_q = st.out_q;
            endcase
        end else if (STANDARD && mode == tm_pkg::MODE_CAP && cap_edge) begin
            // single pulse style response on capture edge
            next_st.out_q = !st.out_q;
        end

        // register writes
        if (wr) begin
            if (hit(paddr, tm_pkg::CTRL0_OFF)) begin
                next_st.ctrl0 = pwdata[7:0];
            end
            if (hit(paddr, tm_pkg::CTRL1_OFF)) begin
                next_st.ctrl1 = pwdata[7:0];
            end
            if (hit(paddr, tm_pkg::PINSEL_OFF)) begin
                next_st.pinsel = pwdata[3:0];
            end
            if (hit(paddr, tm_pkg::IRQMSK_OFF)) begin
                next_st.mask = pwdata[2:0];
            end
            if (hit(paddr, tm_pkg::IRQST_OFF)) begin
                next_st.status = st.status & ~pwdata[2:0];
            end
        end
        // counter restart on enable
        if (on_rise) begin
            next_st.count = '0;
            next_st.out_q = st.ctrl1[tm_pkg::C1_OC];
        end

        next_st.status = next_st.status | {ovf, match_p, match_a};

        // read data captured in setup phase
        next_st.rdata = '0;
        if (rd) begin
            case (paddr)
                tm_pkg::CTRL0_OFF:  next_st.rdata = {24'h0000_00, st.ctrl0};
                tm_pkg::CTRL1_OFF:  next_st.rdata = {24'h0000_00, st.ctrl1};
                tm_pkg::CNTL_OFF:   next_st.rdata = {24'h0000_00, cnt_buf};
                tm_pkg::CNTH_OFF:   next_st.rdata = {30'h0000_0000, st.count[9:8]};
                tm_pkg::CMPL_OFF:   next_st.rdata = {24'h0000_00, cmp_buf};
                tm_pkg::CMPH_OFF:   next_st.rdata = {30'h0000_0000, cmp_a[9:8]};
                tm_pkg::PINSEL_OFF: next_st.rdata = {28'h0000_000, st.pinsel};
                tm_pkg::IRQST_OFF:  next_st.rdata = {29'h0000_0000, st.status};
                tm_pkg::IRQMSK_OFF: next_st.rdata = {29'h0000_0000, st.mask};
                default:            next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic level;  // output after polarity

    assign level = st.out_q ^ st.ctrl1[tm_pkg::C1_POL];
    assign timer_output_pin_a = (level ^ st.pinsel[2]) && st.pinsel[0];
    assign timer_output_en_a  = st.pinsel[0] && (mode != tm_pkg::MODE_TIMER);
    // second pin only on compact type
    assign timer_output_pin_b = !STANDARD && (level ^ st.pinsel[3]) && st.pinsel[1];
    assign timer_output_en_b  = !STANDARD && st.pinsel[1] && (mode != tm_pkg::MODE_TIMER);
    assign ext_input_routed   = ext_routed;
    assign irq                = |(st.status & st.mask);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    // all ones wraps to zero
    AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        ovf && !on_rise |=> st.count == 10'h000)
        else $error("counter did not wrap");

    // wrap sets the overflow flag
    AST_OVF: assert property (@(posedge pclk) disable iff (!presetn)
        ovf |=> st.status[2])
        else $error("overflow event lost");

    // compare a match sets its flag
    AST_A_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        match_a |=> st.status[0])
        else $error("compare a event lost");

    // period match sets its flag
    AST_P_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        match_p |=> st.status[1])
        else $error("period event lost");

    // compare a clears the counter when chosen
    AST_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        match_a && st.ctrl1[tm_pkg::C1_CCLR] |=> st.count == 10'h000)
        else $error("compare a did not clear");

    // drive-high action on a match
    AST_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        match_a && mode == tm_pkg::MODE_CMP && iofn == tm_pkg::IO_HIGH && !on_rise
        |=> st.out_q)
        else $error("output not driven high");

    // drive-low action on a match
    AST_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        match_a && mode == tm_pkg::MODE_CMP && iofn == tm_pkg::IO_LOW && !on_rise
        |=> !st.out_q)
        else $error("output not driven low");

    // toggle action on a match
    AST_TOG: assert property (@(posedge pclk) disable iff (!presetn)
        match_a && mode == tm_pkg::MODE_CMP && iofn == tm_pkg::IO_TOG && !on_rise
        |=> st.out_q != $past(st.out_q))
        else $error("output did not toggle");

    // unselected pin stays quiet
    AST_SEL: assert property (@(posedge pclk) disable iff (!presetn)
        !st.pinsel[0] |-> !timer_output_pin_a && !timer_output_en_a)
        else $error("unselected pin driven");

    // high write commits the buffered low byte
    AST_CMPW: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit(paddr, tm_pkg::CMPH_OFF)
        |=> cmp_a == {$past(pwdata[1:0]), $past(cmp_buf)})
        else $error("compare high write wrong");

    // high read latches the low byte
    AST_CNTR: assert property (@(posedge pclk) disable iff (!presetn)
        rd && hit(paddr, tm_pkg::CNTH_OFF) |=> cnt_buf == $past(st.count[7:0]))
        else $error("counter low not latched");

    // unmasked event raises the line
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        match_a && st.mask[0] && !(wr && hit(paddr, tm_pkg::IRQMSK_OFF)) |=> irq)
        else $error("interrupt not raised");

endmodule // tm_core

// ### dv/tm_far_side.sv
`timescale 1ns/1ps
// external count source on the far side of the pin
module tm_far_side (
    // clock
    input  wire logic pclk,
    // pin toward the timer, idles low
    output logic      ext_pin
);
    initial ext_pin = 1'b0;
    // one rise, one fall per pulse
    task pulses(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            ext_pin <= 1'b1;
            repeat (gap) @(posedge pclk);
            ext_pin <= 1'b0;
            repeat (gap) @(posedge pclk);
        end
    endtask
endmodule // tm_far_side

// ### dv/test_timer_module_common_core.sv
`timescale 1ns/1ps
module test_timer_module_common_core;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r, seed = 32'h0001_51EA;
    logic        pready, pslverr, err, pa, ea, routed, irq, ext;
    logic [9:0]  v, c;
    int          miscompares = 0, n_compared = 0, cyc = 0, k;
    always #5 pclk = ~pclk;
    tm_far_side far_u (.pclk(pclk), .ext_pin(ext));
    // capture input held idle, never more than one enabled
    tm_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_clock_tick(1'b0), .sub_clock_tick(1'b0),
        .external_count_input(ext), .capture_input(1'b0), .timer_output_pin_a(pa),
        .timer_output_pin_b(), .timer_output_en_a(ea), .timer_output_en_b(),
        .ext_input_routed(routed), .irq(irq));
    function logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // pin level after one compare match
    function logic exp_pin(input logic [1:0] fn, input logic init);
        return fn == tm_pkg::IO_HIGH ? 1'b1 : fn == tm_pkg::IO_LOW ? 1'b0 :
               fn == tm_pkg::IO_TOG ? ~init : init;
    endfunction
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        #1;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    // high byte first, then the buffered low byte
    task rd10(input logic [11:0] hi);
        apb(0, hi, 0);
        v[9:8] = r[1:0];
        apb(0, hi - 12'h004, 0);
        v[7:0] = r[7:0];
    endtask
    task tally_and_finish;
        if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        apb(0, tm_pkg::CTRL0_OFF, 0);
        chk("ctrl0", r, 0);
        chk("irq", irq, 0);
        apb(0, 12'h040, 0);
        chk("slverr", err, 1);
        chk("rdata", r, 0);
        // external count input, rising then falling edge
        for (int i = 6; i < 8; i++) begin
            seed = xs(seed);
            k = seed % 20 + 1;
            wr(tm_pkg::CTRL0_OFF, 32'h0000_0008 | (i << 4));
            chk("routed", routed, 1);
            far_u.pulses(k, seed[9:8] + 2);
            repeat (6) @(posedge pclk);
            rd10(tm_pkg::CNTH_OFF);
            chk("count", v, k);
            wr(tm_pkg::CTRL0_OFF, 0);
            chk("routed", routed, 0);
        end
        // every compare output function, random compare value and init level
        wr(tm_pkg::PINSEL_OFF, 1);
        for (int f = 0; f < 4; f++) begin
            seed = xs(seed);
            c = seed[6:0] + 8;
            // low byte to buffer, then high byte commits
            wr(tm_pkg::CMPL_OFF, c[7:0]);
            wr(tm_pkg::CMPH_OFF, c[9:8]);
            wr(tm_pkg::CMPL_OFF, ~c[7:0]);
            rd10(tm_pkg::CMPH_OFF);
            chk("cmpa", v, c);
            wr(tm_pkg::CTRL1_OFF, (f << 4) | (seed[8] << 3) | (f < 3));
            wr(tm_pkg::CTRL0_OFF, 32'h0000_0018);
            repeat (c + 10) @(posedge pclk);
            chk("pin", pa, exp_pin(2'(f), seed[8]));
            chk("en", ea, 1);
            chk("irq", irq, 0);
            wr(tm_pkg::IRQMSK_OFF, 1);
            chk("irq", irq, 1);
            apb(0, tm_pkg::IRQST_OFF, 0);
            chk("status", r, 1);
            wr(tm_pkg::CTRL0_OFF, 0);
            wr(tm_pkg::IRQST_OFF, 1);
            chk("irq", irq, 0);
            wr(tm_pkg::IRQMSK_OFF, 0);
        end
        // period field 1 matches after 128 ticks and clears the counter
        wr(tm_pkg::CTRL0_OFF, 32'h0000_0019);
        repeat (140) @(posedge pclk);
        apb(0, tm_pkg::IRQST_OFF, 0);
        chk("status", r, {1'b1, c <= 10'h080});
        // free run through all ones wraps and flags overflow
        wr(tm_pkg::CTRL0_OFF, 0);
        wr(tm_pkg::IRQST_OFF, 7);
        wr(tm_pkg::IRQMSK_OFF, 4);
        wr(tm_pkg::CTRL0_OFF, 32'h0000_0018);
        repeat (1030) @(posedge pclk);
        chk("irq", irq, 1);
        apb(0, tm_pkg::IRQST_OFF, 0);
        chk("status", r, 5);
        wr(tm_pkg::CTRL1_OFF, 32'h0000_00C0);
        chk("en", ea, 0);
        tally_and_finish;
    end
endmodule // test_timer_module_common_core
